// ==== src/av_stamp_pkg.sv ====
// Constants, types and helpers shared by the AV stamp device end and the codec end.
// What this block does
// RULE_01: Audio features enabled only by control bit 30.
// RULE_02: Audio mode: frame sync rise queues a stamp.
// RULE_03: Stamp nibble adds delay plus two; offset copied.
// RULE_04: Audio stamps leave oldest first, payload packets only.
// RULE_05: Audio stamp waits for next non-empty packet.
// RULE_06: Drop stamp less than one cycle ahead.
// RULE_07: Transmit queue four deep, receive queue six.
// RULE_08: Full receive queue overwrites its newest entry.
// RULE_09: Queue full or corrupt: flush, raise overflow.
// RULE_10: Sync-flag pin mirrored, sent with its block.
// RULE_11: Receive sync flag shown with first byte.
// RULE_12: Six buffer sizes set through indirect space.
// RULE_13: Software resets traffic after resizing buffers.
// RULE_14: Sizes in 64-quadlet steps, 64 quadlets to 11kB.
// RULE_15: Software keeps buffer total within 3K quadlets.
// RULE_16: Reset sizes: async 256, isochronous 1024 quadlets.
// RULE_17: MPEG-2 transport should keep default isochronous sizes.
// RULE_18: Stamp delay two to four cycles, default three.
// RULE_19: Outside audio, stamp goes on next cycle.
// RULE_20: Receive frame sync pulses when head matches timer.
// RULE_21: Overflow flag is bit 14 at 0x04C.
// RULE_22: Stamp nibble sum wraps modulo sixteen.
package av_stamp_pkg;
  // Register byte offsets on the host port.
  localparam logic [7:0] TX_PKT_CTL_OFS = 8'h20;
  localparam logic [7:0] TX_CTL_OFS = 8'h34;
  localparam logic [7:0] IRQ_OFS = 8'h4C;
  localparam logic [7:0] STAT_OFS = 8'h50;
  localparam logic [7:0] IND_ADDR_OFS = 8'hF8;
  localparam logic [7:0] IND_DATA_OFS = 8'hFC;
  // Field positions.
  localparam int AUDIO_BIT = 30;
  localparam int DELAY_LSB = 5;
  localparam int SY_BIT = 0;
  localparam int OVF_BIT = 14;
  localparam int CHG_BIT = 0;
  localparam int POOL_BIT = 1;
  localparam int TXCNT_LSB = 4;
  localparam int RXCNT_LSB = 8;
  localparam int UNIT_LSB = 6;
  // Delay field: value plus two cycles, field 3 meaning four cycles.
  localparam logic [1:0] DELAY_RESET = 2'h1;
  localparam logic [1:0] DELAY_MAX_CODE = 2'h2;
  localparam logic [3:0] DELAY_BASE = 4'h2;
  localparam logic [3:0] AUDIO_EXTRA = 4'h2;
  // Stamp arithmetic.
  localparam logic [3:0] AHEAD_WINDOW = 4'h8;
  localparam logic [3:0] AHEAD_MIN = 4'h1;
  localparam logic [11:0] CYC_OFS_LIMIT = 12'hC00;
  // Queue depths.
  localparam logic [2:0] TXQ_DEPTH = 3'h4;
  localparam logic [2:0] RXQ_DEPTH = 3'h6;
  // Buffer pool in units of 64 quadlets.
  localparam int NUM_BUFS = 6;
  localparam logic [8:0] IND_BUF_BASE = 9'h100;
  localparam logic [9:0] UNIT_MIN = 10'h001;
  localparam logic [9:0] UNIT_MAX = 10'h02C;
  localparam logic [8:0] POOL_UNITS = 9'h030;
  localparam logic [5:0] ASYNC_RESET_UNITS = 6'h04;
  localparam logic [5:0] ISO_RESET_UNITS = 6'h10;
  localparam int ISO_TX_BUF = 4;
  // AV port clock made by the codec end.
  localparam int CLK_PERIOD_NS = 100;
  localparam int AV_PERIOD_NS = 800;
  localparam logic [2:0] AV_HALF_CYCLES = 3'(AV_PERIOD_NS / CLK_PERIOD_NS / 2);

  typedef logic [15:0] stamp_t;

  // Circular index step shared by both stamp queues.
  function automatic logic [2:0] next_idx(input logic [2:0] idx, input logic [2:0] depth);
    next_idx = (idx == depth - 3'h1) ? 3'h0 : idx + 3'h1;
  endfunction
endpackage

// ==== src/av_pins_if.sv ====
// AV port pins joining the device end and the codec end.
`timescale 1ns/1ps
interface av_pins_if;
  logic av_port_clock;
  logic av_frame_sync_pin;
  logic av_frame_flag_pin;
  logic av_valid;
  logic [7:0] av_data;
  logic av_frame_sync_out;
  logic av_frame_flag_out;

  modport device (
    input av_port_clock,
    input av_frame_sync_pin,
    input av_frame_flag_pin,
    input av_valid,
    input av_data,
    output av_frame_sync_out,
    output av_frame_flag_out
  );

  modport codec (
    output av_port_clock,
    output av_frame_sync_pin,
    output av_frame_flag_pin,
    output av_valid,
    output av_data,
    input av_frame_sync_out,
    input av_frame_flag_out
  );
endinterface

// ==== src/av_stamp_device.sv ====
// Device end: stamp queues, sync flag handling and buffer size registers.
`timescale 1ns/1ps
module av_stamp_device (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  av_pins_if.device av, // AV port pins.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_we, // Write strobe.
  input wire logic reg_re, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after the strobe.
  input wire logic [15:0] cycle_time_value, // Bus cycle timer, count and offset.
  input wire logic tx_packet_start, // Transmitter opens an iso packet.
  input wire logic tx_payload_nonempty, // That packet carries data.
  output logic tx_stamp_valid, // Stamp attached to this packet.
  output logic [15:0] tx_stamp, // Stamp value.
  output logic tx_block_valid, // Captured AV byte strobe.
  output logic [7:0] tx_block_data, // Captured AV byte.
  output logic tx_block_sy, // Sync flag travelling with the byte.
  input wire logic rx_stamp_valid, // Receiver delivers a stamp.
  input wire logic [15:0] rx_stamp, // Received stamp.
  input wire logic rx_first_byte, // First byte of a packet leaves the port.
  input wire logic rx_packet_sy // Sync flag of that packet.
);
  localparam int NUM_BUFS = av_stamp_pkg::NUM_BUFS;
  logic fs_meta_q, fs_sync_q, fs_prev_q;
  logic sy_meta_q, sy_sync_q;
  logic ck_meta_q, ck_sync_q, ck_prev_q;
  logic vld_meta_q, vld_sync_q;
  logic [7:0] dat_meta_q, dat_sync_q;
  logic audio_q;
  logic [1:0] delay_q;
  logic [8:0] ind_addr_q;
  logic [5:0] buf_units_q [NUM_BUFS];
  logic ovf_q, chg_q;
  av_stamp_pkg::stamp_t txq_mem [4];
  logic [2:0] txq_rd_q, txq_wr_q, txq_cnt_q;
  av_stamp_pkg::stamp_t rxq_mem [6];
  logic [2:0] rxq_rd_q, rxq_wr_q, rxq_last_q, rxq_cnt_q;
  logic fsync_out_q, flag_out_q;
  logic fs_rise, ck_rise, tx_pop, tx_ovf, rx_match, rx_corrupt, rx_full, rx_ovf;
  logic ind_hit;
  logic [2:0] ind_idx;
  logic [3:0] stamp_nib;
  logic [8:0] pool_units;
  logic [31:0] rd_mux;

  // Pins cross from the AV domain through two flops before any use.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fs_meta_q <= 1'b0;
      fs_sync_q <= 1'b0;
      fs_prev_q <= 1'b0;
      sy_meta_q <= 1'b0;
      sy_sync_q <= 1'b0;
      ck_meta_q <= 1'b0;
      ck_sync_q <= 1'b0;
      ck_prev_q <= 1'b0;
      vld_meta_q <= 1'b0;
      vld_sync_q <= 1'b0;
      dat_meta_q <= 8'h00;
      dat_sync_q <= 8'h00;
    end
    else
    begin
      fs_meta_q <= av.av_frame_sync_pin;
      fs_sync_q <= fs_meta_q;
      fs_prev_q <= fs_sync_q;
      sy_meta_q <= av.av_frame_flag_pin;
      sy_sync_q <= sy_meta_q;
      ck_meta_q <= av.av_port_clock;
      ck_sync_q <= ck_meta_q;
      ck_prev_q <= ck_sync_q;
      vld_meta_q <= av.av_valid;
      vld_sync_q <= vld_meta_q;
      dat_meta_q <= av.av_data;
      dat_sync_q <= dat_meta_q;
    end
  end

  assign fs_rise = fs_sync_q & ~fs_prev_q; // see RULE_02
  assign ck_rise = ck_sync_q & ~ck_prev_q;

  // Delay code 0..2 gives 2..4 cycles; code 3 is held at four cycles.
  function automatic logic [3:0] delay_cycles(input logic [1:0] code);
    logic [1:0] c;
    c = (code > av_stamp_pkg::DELAY_MAX_CODE) ? av_stamp_pkg::DELAY_MAX_CODE : code;
    delay_cycles = av_stamp_pkg::DELAY_BASE + {2'h0, c}; // see RULE_18
  endfunction

  // A stamp must point at least one whole bus cycle past the timer.
  function automatic logic in_future(input logic [15:0] s, input logic [15:0] now);
    logic [3:0] dn;
    dn = s[15:12] - now[15:12];
    in_future = (dn > av_stamp_pkg::AHEAD_MIN && dn < av_stamp_pkg::AHEAD_WINDOW)
      || (dn == av_stamp_pkg::AHEAD_MIN && s[11:0] >= now[11:0]);
  endfunction

  // Four-bit sum wraps by width; audio mode adds its extra two cycles.
  assign stamp_nib = 4'(cycle_time_value[15:12] + delay_cycles(delay_q)
    + (audio_q ? av_stamp_pkg::AUDIO_EXTRA : 4'h0)); // see RULE_03 RULE_22 RULE_01

  // Audio mode pops only on payload packets; otherwise on every packet.
  assign tx_pop = tx_packet_start && (txq_cnt_q != 3'h0)
    && (!audio_q || tx_payload_nonempty); // see RULE_04 RULE_05 RULE_19
  assign tx_ovf = fs_rise && !tx_pop && (txq_cnt_q == av_stamp_pkg::TXQ_DEPTH); // see RULE_09

  // Transmit stamp queue, four entries of flops.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      txq_rd_q <= 3'h0;
      txq_wr_q <= 3'h0;
      txq_cnt_q <= 3'h0;
    end
    else if (tx_ovf)
    begin
      txq_rd_q <= 3'h0; // see RULE_09
      txq_wr_q <= 3'h0;
      txq_cnt_q <= 3'h0;
    end
    else
    begin
      if (fs_rise)
      begin
        txq_mem[txq_wr_q[1:0]] <= {stamp_nib, cycle_time_value[11:0]}; // see RULE_03
        txq_wr_q <= av_stamp_pkg::next_idx(txq_wr_q, av_stamp_pkg::TXQ_DEPTH); // see RULE_07
      end
      if (tx_pop)
        txq_rd_q <= av_stamp_pkg::next_idx(txq_rd_q, av_stamp_pkg::TXQ_DEPTH); // see RULE_04
      txq_cnt_q <= txq_cnt_q + {2'h0, fs_rise} - {2'h0, tx_pop};
    end
  end

  // Stamp handed to the transmitter for one cycle; stale ones are dropped.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_stamp_valid <= 1'b0;
      tx_stamp <= 16'h0000;
    end
    else
    begin
      tx_stamp_valid <= tx_pop
        && in_future(txq_mem[txq_rd_q[1:0]], cycle_time_value); // see RULE_06
      if (tx_pop)
        tx_stamp <= txq_mem[txq_rd_q[1:0]];
    end
  end

  assign rx_match = (rxq_cnt_q != 3'h0) && (rxq_mem[rxq_rd_q] == cycle_time_value);
  assign rx_corrupt = rx_stamp_valid && (rx_stamp[11:0] >= av_stamp_pkg::CYC_OFS_LIMIT);
  assign rx_full = (rxq_cnt_q == av_stamp_pkg::RXQ_DEPTH) && !rx_match;
  assign rx_ovf = rx_corrupt;

  // Receive stamp queue, six entries; a corrupt stamp flushes it.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rxq_rd_q <= 3'h0;
      rxq_wr_q <= 3'h0;
      rxq_last_q <= 3'h0;
      rxq_cnt_q <= 3'h0;
    end
    else if (rx_corrupt)
    begin
      rxq_rd_q <= 3'h0; // see RULE_09
      rxq_wr_q <= 3'h0;
      rxq_last_q <= 3'h0;
      rxq_cnt_q <= 3'h0;
    end
    else
    begin
      if (rx_stamp_valid && rx_full)
        rxq_mem[rxq_last_q] <= rx_stamp; // see RULE_08
      else if (rx_stamp_valid)
      begin
        rxq_mem[rxq_wr_q] <= rx_stamp;
        rxq_last_q <= rxq_wr_q;
        rxq_wr_q <= av_stamp_pkg::next_idx(rxq_wr_q, av_stamp_pkg::RXQ_DEPTH); // see RULE_07
      end
      if (rx_match)
        rxq_rd_q <= av_stamp_pkg::next_idx(rxq_rd_q, av_stamp_pkg::RXQ_DEPTH);
      rxq_cnt_q <= rxq_cnt_q + {2'h0, rx_stamp_valid && !rx_full} - {2'h0, rx_match};
    end
  end

  // Frame sync out is a one-clock pulse, not tied to the AV port clock.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      fsync_out_q <= 1'b0;
    else
      fsync_out_q <= rx_match; // see RULE_20
  end

  // Receive flag stands for the AV cycle of the first byte, then drops.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      flag_out_q <= 1'b0;
    else if (rx_first_byte)
      flag_out_q <= rx_packet_sy; // see RULE_11
    else if (ck_rise)
      flag_out_q <= 1'b0;
  end

  assign av.av_frame_sync_out = fsync_out_q;
  assign av.av_frame_flag_out = flag_out_q;

  // Each AV byte is taken on the port clock rise with its sync flag.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_block_valid <= 1'b0;
      tx_block_data <= 8'h00;
      tx_block_sy <= 1'b0;
    end
    else
    begin
      tx_block_valid <= ck_rise && vld_sync_q;
      if (ck_rise && vld_sync_q)
      begin
        tx_block_data <= dat_sync_q;
        tx_block_sy <= sy_sync_q; // see RULE_10
      end
    end
  end

  assign ind_idx = ind_addr_q[4:2];
  assign ind_hit = ind_addr_q[8] && (ind_addr_q[7:5] == 3'h0) && (ind_addr_q[1:0] == 2'h0)
    && (ind_idx < 3'(NUM_BUFS)); // see RULE_12

  // Size written in quadlets, rounded down to 64 and held inside limits.
  function automatic logic [5:0] clamp_units(input logic [9:0] u);
    if (u < av_stamp_pkg::UNIT_MIN)
      clamp_units = av_stamp_pkg::UNIT_MIN[5:0];
    else if (u > av_stamp_pkg::UNIT_MAX)
      clamp_units = av_stamp_pkg::UNIT_MAX[5:0];
    else
      clamp_units = u[5:0];
  endfunction

  // Host-written control fields and buffer sizes.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      audio_q <= 1'b0;
      delay_q <= av_stamp_pkg::DELAY_RESET; // see RULE_18
      ind_addr_q <= 9'h000;
      for (int i = 0; i < NUM_BUFS; i++)
        buf_units_q[i] <= (i >= av_stamp_pkg::ISO_TX_BUF) ? av_stamp_pkg::ISO_RESET_UNITS
          : av_stamp_pkg::ASYNC_RESET_UNITS; // see RULE_16
    end
    else if (reg_we)
    begin
      if (reg_addr == av_stamp_pkg::TX_PKT_CTL_OFS)
      begin
        audio_q <= reg_wdata[av_stamp_pkg::AUDIO_BIT]; // see RULE_01
        delay_q <= reg_wdata[av_stamp_pkg::DELAY_LSB +: 2];
      end
      if (reg_addr == av_stamp_pkg::IND_ADDR_OFS)
        ind_addr_q <= reg_wdata[8:0];
      if (reg_addr == av_stamp_pkg::IND_DATA_OFS && ind_hit)
        buf_units_q[ind_idx] <=
          clamp_units(reg_wdata[av_stamp_pkg::UNIT_LSB +: 10]); // see RULE_14
    end
  end

  // Sticky flags: a setting event wins over a clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ovf_q <= 1'b0;
      chg_q <= 1'b0;
    end
    else
    begin
      ovf_q <= tx_ovf || rx_ovf || (ovf_q && !(reg_we && reg_addr == av_stamp_pkg::IRQ_OFS
        && reg_wdata[av_stamp_pkg::OVF_BIT])); // see RULE_09 RULE_21
      chg_q <= (reg_we && reg_addr == av_stamp_pkg::IND_DATA_OFS && ind_hit)
        || (chg_q && !(reg_we && reg_addr == av_stamp_pkg::STAT_OFS
        && reg_wdata[av_stamp_pkg::CHG_BIT])); // see RULE_13
    end
  end

  // Pool total lets software see an oversubscribed buffer plan.
  always_comb
  begin
    pool_units = 9'h000;
    for (int i = 0; i < NUM_BUFS; i++)
      pool_units = pool_units + {3'h0, buf_units_q[i]}; // see RULE_15
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      av_stamp_pkg::TX_PKT_CTL_OFS:
      begin
        rd_mux[av_stamp_pkg::AUDIO_BIT] = audio_q;
        rd_mux[av_stamp_pkg::DELAY_LSB +: 2] = delay_q;
      end
      av_stamp_pkg::TX_CTL_OFS: rd_mux[av_stamp_pkg::SY_BIT] = sy_sync_q; // see RULE_10
      av_stamp_pkg::IRQ_OFS: rd_mux[av_stamp_pkg::OVF_BIT] = ovf_q;
      av_stamp_pkg::STAT_OFS:
      begin
        rd_mux[av_stamp_pkg::CHG_BIT] = chg_q;
        rd_mux[av_stamp_pkg::POOL_BIT] = pool_units > av_stamp_pkg::POOL_UNITS;
        rd_mux[av_stamp_pkg::TXCNT_LSB +: 3] = txq_cnt_q;
        rd_mux[av_stamp_pkg::RXCNT_LSB +: 3] = rxq_cnt_q;
      end
      av_stamp_pkg::IND_ADDR_OFS: rd_mux[8:0] = ind_addr_q;
      av_stamp_pkg::IND_DATA_OFS:
        if (ind_hit)
          rd_mux[av_stamp_pkg::UNIT_LSB +: 6] = buf_units_q[ind_idx];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_re ? rd_mux : 32'h0000_0000;
  end
endmodule // av_stamp_device

// ==== src/av_codec_end.sv ====
// Codec end: makes the AV port clock, drives bytes and flags, watches device outputs.
`timescale 1ns/1ps
module av_codec_end (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  av_pins_if.codec av, // AV port pins.
  input wire logic fsync_req, // Request one frame sync pulse.
  input wire logic byte_valid, // Byte offered for sending.
  input wire logic [7:0] byte_data, // Byte value.
  input wire logic byte_sy, // Sync flag for that byte.
  output logic byte_ready, // Byte holding register is free.
  output logic rx_fsync_seen, // Device frame sync rise seen.
  output logic rx_frame_flag // Device sync flag level.
);
  logic [2:0] div_q;
  logic avclk_q, half_done, fall;
  logic hold_v_q, hold_sy_q, accept, hold_v_d;
  logic [7:0] hold_d_q;
  logic fs_pend_q, fs_pin_q, sy_pin_q, vld_pin_q;
  logic [7:0] dat_pin_q;
  logic fso_meta_q, fso_sync_q, fso_prev_q, flg_meta_q, flg_sync_q;

  assign half_done = (div_q == av_stamp_pkg::AV_HALF_CYCLES - 3'h1);
  assign fall = half_done && avclk_q;

  // Divider makes the AV port clock from the system clock.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div_q <= 3'h0;
      avclk_q <= 1'b0;
    end
    else if (half_done)
    begin
      div_q <= 3'h0;
      avclk_q <= ~avclk_q;
    end
    else
      div_q <= div_q + 3'h1;
  end

  assign accept = byte_valid && byte_ready;
  assign hold_v_d = accept || (hold_v_q && !fall);

  // One byte of holding; the user stalls while it is occupied.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hold_v_q <= 1'b0;
      hold_d_q <= 8'h00;
      hold_sy_q <= 1'b0;
      byte_ready <= 1'b1;
    end
    else
    begin
      hold_v_q <= hold_v_d;
      byte_ready <= !hold_v_d;
      if (accept)
      begin
        hold_d_q <= byte_data;
        hold_sy_q <= byte_sy;
      end
    end
  end

  // Pins change on the falling edge so they stand still at the rise.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fs_pend_q <= 1'b0;
      fs_pin_q <= 1'b0;
      sy_pin_q <= 1'b0;
      vld_pin_q <= 1'b0;
      dat_pin_q <= 8'h00;
    end
    else
    begin
      fs_pend_q <= fsync_req || (fs_pend_q && !fall);
      if (fall)
      begin
        fs_pin_q <= fs_pend_q;
        vld_pin_q <= hold_v_q;
        if (hold_v_q)
        begin
          dat_pin_q <= hold_d_q;
          sy_pin_q <= hold_sy_q; // see RULE_10
        end
      end
    end
  end

  assign av.av_port_clock = avclk_q;
  assign av.av_frame_sync_pin = fs_pin_q;
  assign av.av_frame_flag_pin = sy_pin_q;
  assign av.av_valid = vld_pin_q;
  assign av.av_data = dat_pin_q;

  // Device outputs are synchronised before use.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fso_meta_q <= 1'b0;
      fso_sync_q <= 1'b0;
      fso_prev_q <= 1'b0;
      flg_meta_q <= 1'b0;
      flg_sync_q <= 1'b0;
      rx_fsync_seen <= 1'b0;
      rx_frame_flag <= 1'b0;
    end
    else
    begin
      fso_meta_q <= av.av_frame_sync_out;
      fso_sync_q <= fso_meta_q;
      fso_prev_q <= fso_sync_q;
      flg_meta_q <= av.av_frame_flag_out;
      flg_sync_q <= flg_meta_q;
      rx_fsync_seen <= fso_sync_q && !fso_prev_q; // see RULE_20
      rx_frame_flag <= flg_sync_q; // see RULE_11
    end
  end
endmodule // av_codec_end

// ==== tb/av_pin_monitor.sv ====
// Checker on the AV port pins between the device end and the codec end.
`timescale 1ns/1ps
module av_pin_monitor (
  input wire logic clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic av_port_clock, // AV port clock.
  input wire logic av_frame_sync_pin, // Codec frame sync.
  input wire logic av_frame_flag_pin, // Codec sync flag.
  input wire logic av_valid, // Codec byte strobe.
  input wire logic [7:0] av_data, // Codec byte.
  input wire logic av_frame_sync_out, // Device frame sync pulse.
  input wire logic av_frame_flag_out // Device sync flag.
);
  // One clock domain.
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Device frame sync is one clock long.
  AST_SYNC_OUT_PULSE: assert property (av_frame_sync_out |=> !av_frame_sync_out)
    else $error("frame sync output too long");
  // AV clock: four clocks each phase.
  AST_AVCLK_HIGH: assert property ($rose(av_port_clock) |->
    av_port_clock [*4] ##1 !av_port_clock)
    else $error("AV clock high phase wrong");
  AST_AVCLK_LOW: assert property ($fell(av_port_clock) |->
    !av_port_clock [*4] ##1 av_port_clock)
    else $error("AV clock low phase wrong");
  // Pins move only at the AV clock fall.
  AST_BYTE_AT_FALL: assert property ($changed({av_valid, av_data}) |->
    $fell(av_port_clock))
    else $error("byte pins moved off the fall");
  AST_FLAG_AT_FALL: assert property ($changed(av_frame_flag_pin) |->
    $fell(av_port_clock))
    else $error("flag pin moved off the fall");
  AST_FSYNC_AT_FALL: assert property ($changed(av_frame_sync_pin) |->
    $fell(av_port_clock))
    else $error("sync pin moved off the fall");
  AST_FSYNC_ONE_PERIOD: assert property ($rose(av_frame_sync_pin) |->
    av_frame_sync_pin [*8] ##1 !av_frame_sync_pin)
    else $error("sync pin not one AV period");
  // Receive flag falls within twelve clocks, one and a half AV cycles.
  AST_FLAG_OUT_BOUND: assert property ($rose(av_frame_flag_out) |->
    ##[1:12] !av_frame_flag_out)
    else $error("receive flag held too long");

  // Main traffic seen at the pins.
  COV_SYNC_OUT: cover property (av_frame_sync_out);
  COV_FLAG_OUT: cover property ($rose(av_frame_flag_out));
  COV_BYTE: cover property (av_valid && $rose(av_port_clock));
endmodule // av_pin_monitor

// ==== tb/av_syt_stamp_and_buffer_config_test.sv ====
// Self-checking bench joining the device end and the codec end.
`timescale 1ns/1ps
module av_syt_stamp_and_buffer_config_test;
  logic clk = 1'b0;
  logic resetn, reg_we, reg_re, tx_packet_start, tx_payload_nonempty, fsync_req;
  logic rx_stamp_valid, rx_first_byte, rx_packet_sy, byte_valid, byte_sy, byte_ready;
  logic tx_stamp_valid, tx_block_valid, tx_block_sy, rx_fsync_seen, rx_frame_flag;
  logic [7:0] reg_addr, byte_data, tx_block_data;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [15:0] cyc, tx_stamp, rx_stamp;
  int num_errors = 0;
  int cmp_count = 0;

  // System clock, 100 ns period.
  always #50 clk = ~clk;

  // Both ends over the pin interface.
  av_pins_if av_pins_if_inst ();
  av_stamp_device av_stamp_device_inst (.clk, .resetn, .av(av_pins_if_inst), .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata, .cycle_time_value(cyc), .tx_packet_start,
    .tx_payload_nonempty, .tx_stamp_valid, .tx_stamp, .tx_block_valid, .tx_block_data,
    .tx_block_sy, .rx_stamp_valid, .rx_stamp, .rx_first_byte, .rx_packet_sy);
  av_codec_end av_codec_end_inst (.clk, .resetn, .av(av_pins_if_inst), .fsync_req, .byte_valid,
    .byte_data, .byte_sy, .byte_ready, .rx_fsync_seen, .rx_frame_flag);
  av_pin_monitor av_pin_monitor_inst (.clk, .resetn,
    .av_port_clock(av_pins_if_inst.av_port_clock),
    .av_frame_sync_pin(av_pins_if_inst.av_frame_sync_pin),
    .av_frame_flag_pin(av_pins_if_inst.av_frame_flag_pin),
    .av_valid(av_pins_if_inst.av_valid), .av_data(av_pins_if_inst.av_data),
    .av_frame_sync_out(av_pins_if_inst.av_frame_sync_out),
    .av_frame_flag_out(av_pins_if_inst.av_frame_flag_out));

  // Counts, verdict, end of run.
  task automatic report_and_stop();
    $display("mismatches %0d of %0d compares", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Counted compare.
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Bus write, then one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask

  // Bus read; a zero mask only polls.
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    rdv = reg_rdata;
    if (m !== 32'h0)
      cmp(e, rdv & m);
    @(posedge clk);
  endtask

  // Two reset clocks, one idle edge.
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask

  // Control register and buffer sizes after reset.
  task automatic defaults();
    rdc(8'h20, 32'h4000_0060, 32'h0000_0020);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'hF8, 32'h100 + 32'(4 * i));
      rdc(8'hFC, 32'hFFFF_FFFF, (i < 4) ? 32'h100 : 32'h400);
    end
  endtask

  // Frame sync through the codec, then settle time.
  task automatic fsync();
    fsync_req <= 1'b1;
    @(posedge clk);
    fsync_req <= 1'b0;
    repeat (24) @(posedge clk);
  endtask

  // One transmit packet and its stamp.
  task automatic pkt(input logic p, input logic ev, input logic [15:0] es);
    tx_packet_start <= 1'b1;
    tx_payload_nonempty <= p;
    @(posedge clk);
    tx_packet_start <= 1'b0;
    @(negedge clk);
    cmp(32'(ev), 32'(tx_stamp_valid));
    if (ev)
      cmp(32'(es), 32'(tx_stamp));
    @(posedge clk);
  endtask

  // Hands one received stamp to the device.
  task automatic rxs(input logic [15:0] v);
    rx_stamp_valid <= 1'b1;
    rx_stamp <= v;
    @(posedge clk);
    rx_stamp_valid <= 1'b0;
    @(posedge clk);
  endtask

  // Sets the timer; checks frame sync at both ends.
  task automatic match(input logic [15:0] v, input logic e);
    cyc <= v;
    @(posedge clk);
    @(negedge clk);
    cmp(32'(e), 32'(av_pins_if_inst.av_frame_sync_out));
    for (int n = 0; n < 8 && e && rx_fsync_seen !== 1'b1; n++)
      @(negedge clk);
    cmp(32'(e), 32'(rx_fsync_seen));
    @(posedge clk);
  endtask

  // First received byte, started in the AV clock low phase.
  task automatic flagrx(input logic f);
    for (int n = 0; n < 12 && av_pins_if_inst.av_port_clock !== 1'b0; n++)
      @(posedge clk);
    rx_first_byte <= 1'b1;
    rx_packet_sy <= f;
    @(posedge clk);
    rx_first_byte <= 1'b0;
    @(negedge clk);
    cmp(32'(f), 32'(av_pins_if_inst.av_frame_flag_out));
    @(posedge clk);
  endtask

  // Sends one byte; checks mirrored flag and captured block.
  task automatic byte_tx(input logic [7:0] d, input logic f);
    byte_valid <= 1'b1;
    byte_data <= d;
    byte_sy <= f;
    @(posedge clk);
    byte_valid <= 1'b0;
    rdv[0] = ~f;
    for (int n = 0; n < 8 && rdv[0] !== f; n++)
      rdc(8'h34, 32'h0, 32'h0);
    cmp(32'(f), 32'(rdv[0]));
    for (int n = 0; n < 16 && tx_block_valid !== 1'b1; n++)
      @(negedge clk);
    cmp({23'h0, f, d}, {23'h0, tx_block_sy, tx_block_data});
    @(posedge clk);
  endtask

  // Cuts a hung run short.
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    {resetn, reg_we, reg_re, tx_packet_start, tx_payload_nonempty, fsync_req} = '0;
    {rx_stamp_valid, rx_first_byte, rx_packet_sy, byte_valid, byte_sy} = '0;
    {reg_addr, byte_data, reg_wdata, cyc, rx_stamp, rdv} = '0;
    do_reset();
    defaults();
    wr(8'hF8, 32'h100);
    wr(8'hFC, 32'h0);
    rdc(8'hFC, 32'hFFFF_FFFF, 32'h40);
    wr(8'hFC, 32'hFFC0);
    rdc(8'hFC, 32'hFFFF_FFFF, 32'hB00);
    rdc(8'h50, 32'h3, 32'h3);
    wr(8'hFC, 32'h100);
    wr(8'h50, 32'h1);
    rdc(8'h50, 32'h3, 32'h0);
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0);
    wr(8'hF8, 32'h120);
    rdc(8'hFC, 32'hFFFF_FFFF, 32'h0);
    wr(8'hF8, 32'h100);
    wr(8'hFC, 32'h200);
    do_reset();
    defaults();
    // Plain mode: stamp leaves on the next packet, payload or not.
    cyc <= 16'h3123;
    fsync();
    rdc(8'h50, 32'h70, 32'h10);
    pkt(1'b0, 1'b1, 16'h6123);
    // Audio mode, shortest delay; nibble wraps.
    wr(8'h20, 32'h4000_0000);
    cyc <= 16'hE456;
    fsync();
    cyc <= 16'hE789;
    fsync();
    pkt(1'b0, 1'b0, 16'h0);
    pkt(1'b1, 1'b1, 16'h2456);
    pkt(1'b1, 1'b1, 16'h2789);
    cyc <= 16'h1000;
    fsync();
    cyc <= 16'h4800;
    pkt(1'b1, 1'b0, 16'h0);
    rdc(8'h50, 32'h70, 32'h0);
    // Four stamps fit; a fifth flushes and flags overflow.
    repeat (4) fsync();
    rdc(8'h50, 32'h70, 32'h40);
    fsync();
    rdc(8'h50, 32'h70, 32'h0);
    rdc(8'h4C, 32'h4000, 32'h4000);
    wr(8'h4C, 32'h4000);
    rdc(8'h4C, 32'h4000, 32'h0);
    // Receive queue: six fit, a seventh replaces the newest.
    for (int i = 0; i < 6; i++)
      rxs(16'h1100 + 16'(i));
    rxs(16'h1200);
    rdc(8'h50, 32'h700, 32'h600);
    for (int i = 0; i < 5; i++)
      match(16'h1100 + 16'(i), 1'b1);
    match(16'h1105, 1'b0);
    match(16'h1200, 1'b1);
    rxs(16'h1300);
    rxs(16'h0C00);
    rdc(8'h50, 32'h700, 32'h0);
    rdc(8'h4C, 32'h4000, 32'h4000);
    flagrx(1'b1);
    flagrx(1'b0);
    byte_tx(8'hA5, 1'b1);
    byte_tx(8'h5A, 1'b0);
    report_and_stop();
  end
endmodule // av_syt_stamp_and_buffer_config_test
